// file: bench/fss_freq_slope_stage_tb.sv
`timescale 1ns/10ps
`default_nettype none
module fss_freq_slope_stage_tb;
   import fss_pkg::*;
   localparam int TC = 20;
   typedef struct {logic [6:0] sl; logic [9:0] top; logic [9:0] minimum_trip_delay; fss_slope_t s; int n;} fss_row_t;
   // expected n: ticks from start-sequence begin to trip (start output at tick 6); last row is out of range and clamped, low-slope bound rules
   fss_row_t rows [4] = '{'{7'h0A, 10'h00A, 10'h00A, 16'sh00C8, 20}, '{7'h0A, 10'h01E, 10'h008, 16'sh00C8, 30},
      '{7'h0A, 10'h01E, 10'h008, 16'sh0190, 16}, '{7'h00, 10'h000, 10'h000, 16'shFF9C, 50}};
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   fss_addr_t s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_q;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, start_out, trip_out, irq;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   fss_slope_t freq_slope, slope_set = 16'sh0000;
   fss_volt_t volt_ab, volt_bc, volt_ca, volt_set = 11'h3E8;
   logic [7:0] trip_count;
   int n_fail = 0, tests_run = 0, cyc = 0, t0, ts;
   fss_freq_slope_stage #(.TICK_CYCLES(TC)) fss_freq_slope_stage_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .freq_slope, .volt_ab, .volt_bc, .volt_ca, .start_out, .trip_out, .irq);
   fss_line_model fss_line_model_i (.aclk, .aresetn, .slope_set, .volt_set, .trip_out, .freq_slope, .volt_ab,
      .volt_bc, .volt_ca, .trip_count);
   initial forever #12.5 aclk = ~aclk;
   always @(posedge aclk) cyc <= cyc + 1;
   task report_and_stop;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wr(input fss_addr_t a, input logic [31:0] d, input logic [3:0] st);
      bit aw, w;
      aw = 0;
      w = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= st;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (!aw && s_axi_awready) begin
            aw = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task rd(input fss_addr_t a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      rd_q = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   task wait_start;
      t0 = cyc;
      do @(posedge aclk); while (!start_out);
      ts = cyc;
      chk(32'(ts - t0 >= 13 * TC && ts - t0 <= 14 * TC + 3), 32'h1);
   endtask
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(ADDR_CTRL);
      chk(rd_q, 32'h0);
      rd(ADDR_LOW_VOLTAGE_BLOCK_LIMIT);
      chk(rd_q, {25'h0, LOW_VOLTAGE_BLOCK_LIMIT_RESET});
      rd(ADDR_IRQ_EN);
      chk(rd_q, 32'h0);
      rd(ADDR_GROUP_BASE);
      chk(rd_q, {5'h00, GROUP_RESET});
      rd(8'hFC);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
      wr(8'hFC, 32'h1, 4'hF);
      chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
      wr(ADDR_STATUS, 32'h3F, 4'hF);
      rd(ADDR_STATUS);
      chk(rd_q, 32'h0);
      $display("reset and map test done");
      for (int i = 0; i < 4; i++) begin
         wr(ADDR_GROUP_BASE + 8'(4 * i), {5'h00, rows[i].minimum_trip_delay, rows[i].top, rows[i].sl}, 4'hF);
         wr(ADDR_CTRL, {29'h0, 2'(i), 1'b1}, 4'hF);
         slope_set <= rows[i].s;
         wait_start();
         do @(posedge aclk); while (!trip_out);
         chk(32'(cyc - ts), 32'((rows[i].n - 6) * TC));
         slope_set <= 16'sh0000;
         wr(ADDR_CTRL, 32'h0, 4'hF);
         chk({30'h0, start_out, trip_out}, 32'h0);
         $display("row %0d done", i);
      end
      chk({24'h0, trip_count}, 32'h4);
      wr(ADDR_CTRL, 32'h1, 4'hF);
      slope_set <= 16'sh00C8;
      wait_start();
      slope_set <= 16'sh0000;
      repeat (5 * TC) @(posedge aclk);
      chk({31'h0, start_out}, 32'h1);
      do @(posedge aclk); while (start_out);
      chk(32'(cyc - ts >= 15 * TC && cyc - ts <= 17 * TC), 32'h1);
      chk({24'h0, trip_count}, 32'h4);
      wr(ADDR_CTRL, 32'h0, 4'hF);
      $display("average release test done");
      wr(ADDR_LOW_VOLTAGE_BLOCK_LIMIT, 32'hFFFFFF32, 4'h1);
      rd(ADDR_LOW_VOLTAGE_BLOCK_LIMIT);
      chk(rd_q, 32'h32);
      wr(ADDR_IRQ_CLR, 32'h7, 4'hF);
      wr(ADDR_IRQ_EN, 32'h4, 4'hF);
      wr(ADDR_CTRL, 32'h1, 4'hF);
      slope_set <= 16'sh00C8;
      volt_set <= 11'h000;
      repeat (20 * TC) @(posedge aclk);
      chk({30'h0, start_out, irq}, 32'h1);
      wr(ADDR_IRQ_EN, 32'h0, 4'hF);
      chk({31'h0, irq}, 32'h0);
      rd(ADDR_IRQ_STAT);
      chk(rd_q, 32'h4);
      wr(ADDR_IRQ_CLR, 32'h4, 4'hF);
      wr(ADDR_IRQ_EN, 32'h4, 4'hF);
      rd(ADDR_IRQ_STAT);
      chk({rd_q[31:1], irq}, 32'h0);
      volt_set <= 11'h258;
      wait_start();
      rd(ADDR_STATUS);
      chk(rd_q, 32'h19);
      $display("block and interrupt test done");
      report_and_stop();
   end
   initial begin
      repeat (40000) @(posedge aclk);
      n_fail++;
      report_and_stop();
   end
endmodule // fss_freq_slope_stage_tb
bind fss_freq_slope_stage fss_stage_properties fss_stage_properties_i (.aclk, .aresetn, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .volt_ab, .volt_bc, .volt_ca,
   .start_out, .trip_out);
`default_nettype wire

// file: bench/fss_line_model.sv
`timescale 1ns/10ps
`default_nettype none
module fss_line_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire fss_pkg::fss_slope_t slope_set,
   input wire fss_pkg::fss_volt_t volt_set,
   input wire logic trip_out,
   output var fss_pkg::fss_slope_t freq_slope = 16'sh0000,
   output var fss_pkg::fss_volt_t volt_ab = 11'h3E8,
   output var fss_pkg::fss_volt_t volt_bc = 11'h3E8,
   output var fss_pkg::fss_volt_t volt_ca = 11'h3E8,
   output var logic [7:0] trip_count = 8'h00
);
   import fss_pkg::*;
   logic [1:0] ph_q = 2'h0;
   logic trip_q = 1'b0;
   // largest phase rotates so only the maximum can lift the block
   always @(posedge aclk) begin
      freq_slope <= slope_set;
      ph_q <= (ph_q == 2'h2 || !aresetn) ? 2'h0 : ph_q + 2'h1;
      volt_ab <= (ph_q == 2'h0) ? volt_set : volt_set >> 2;
      volt_bc <= (ph_q == 2'h1) ? volt_set : volt_set >> 2;
      volt_ca <= (ph_q == 2'h2) ? volt_set : volt_set >> 2;
      trip_q <= trip_out;
      if (trip_out && !trip_q) begin
         trip_count <= trip_count + 8'h01;
      end
   end
endmodule // fss_line_model
`default_nettype wire

// file: bench/fss_stage_properties.sv
`timescale 1ns/10ps
`default_nettype none
module fss_stage_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire fss_pkg::fss_addr_t s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire fss_pkg::fss_addr_t s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire fss_pkg::fss_volt_t volt_ab,
   input wire fss_pkg::fss_volt_t volt_bc,
   input wire fss_pkg::fss_volt_t volt_ca,
   input wire logic start_out,
   input wire logic trip_out
);
   import fss_pkg::*;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_dead;
      (volt_ab == 11'h000 && volt_bc == 11'h000 && volt_ca == 11'h000) [*3];
   endsequence
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // readies drop at once, response one cycle later
   sequence s_b_answer;
      !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
   endsequence
   property p_trip_needs_start;
      trip_out |-> start_out;
   endproperty
   property p_trip_drop;
      $fell(trip_out) |-> !start_out;
   endproperty
   property p_trip_rise;
      $rose(trip_out) |-> $past(start_out);
   endproperty
   property p_block;
      s_dead |=> !start_out && !trip_out;
   endproperty
   property p_b_follow;
      s_wr_take |=> s_b_answer;
   endproperty
   property p_wr_unmapped;
      s_wr_take ##0 (s_axi_awaddr == 8'hFC) |=> ##1 (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   endproperty
   property p_r_follow;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
   endproperty
   property p_rd_unmapped;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'hFC |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_trip_needs_start: assert property (p_trip_needs_start)
      else $error("trip high without start");
   a_trip_drop: assert property (p_trip_drop)
      else $error("trip dropped while start stays");
   a_trip_rise: assert property (p_trip_rise)
      else $error("trip rose before start");
   a_block: assert property (p_block)
      else $error("output active under low voltage");
   a_b_follow: assert property (p_b_follow)
      else $error("write response late");
   a_wr_unmapped: assert property (p_wr_unmapped)
      else $error("unmapped write not refused");
   a_r_follow: assert property (p_r_follow)
      else $error("read data late");
   a_rd_unmapped: assert property (p_rd_unmapped)
      else $error("unmapped read not refused");
endmodule // fss_stage_properties
`default_nettype wire

// file: core/fss_freq_slope_stage.sv
// The AXI4-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - start sequence begins after |slope| exceeds setting for 80 ms continuously
// - start output asserts a further fixed 60 ms later
// - at operate delay, trip only if average slope since start exceeds setting
// - minimum delay equal to operate delay gives definite-time decision
// - reset when slope stable 80 ms and operate delay passed without trip
// - no release on slope fluctuation; average keeps accumulating from start
// - dependent mode trip time is setting times delay over average slope
// - dependent trip time never below the minimum delay setting
// - slope setting 0.2 to 10.0 Hz/s in 0.1 Hz/s steps
// - delay settings 0.14 s to 10.00 s in 0.02 s steps
// - slope settings below 0.7 Hz/s raise the least operate time
// - four setting groups, each with slope, operate and minimum delay
// - blocked by the common low-voltage block limit of frequency stages
// - block while largest line-to-line voltage is below limit percentage
module fss_freq_slope_stage #(
   parameter int unsigned TICK_CYCLES = fss_pkg::TICK_CYCLES_DEF,
   parameter int unsigned LOW_BASE_TICKS = fss_pkg::LOW_BASE_TICKS_DEF,
   parameter int unsigned LOW_STEP_TICKS = fss_pkg::LOW_STEP_TICKS_DEF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire fss_pkg::fss_addr_t s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire fss_pkg::fss_addr_t s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire fss_pkg::fss_slope_t freq_slope,
   input wire fss_pkg::fss_volt_t volt_ab,
   input wire fss_pkg::fss_volt_t volt_bc,
   input wire fss_pkg::fss_volt_t volt_ca,
   output logic start_out,
   output logic trip_out,
   output logic irq
);
   import fss_pkg::*;

   generate
      if (LOW_BASE_TICKS + 6 * LOW_STEP_TICKS > 3000) begin : g_bad_low
         $error("low-slope bound does not fit the elapsed counter");
      end
   endgenerate

   logic tick;

   fss_tick_divider #(
      .DIV(TICK_CYCLES)
   ) u_tick (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick(tick)
   );

   // register state
   logic [2:0] ctrl_q;
   logic [6:0] low_voltage_block_limit_q;
   logic [2:0] irq_en_q;
   fss_events_t irq_stat_q;
   fss_group_t grp_q [GROUPS];
   fss_addr_t awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   // stage state
   fss_state_t state_q;
   logic [7:0] ph_q;
   logic [7:0] stab_q;
   logic [11:0] n_q;
   logic [31:0] sum_q;
   logic blocked_q;
   logic start_dly_q;
   logic trip_dly_q;

   // write path decode
   wire logic do_write = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
   wire logic [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   wire logic [31:0] wmasked = wdata_q & wmask;
   wire logic wr_ctrl = (awaddr_q == ADDR_CTRL);
   wire logic wr_low_voltage_block_limit = (awaddr_q == ADDR_LOW_VOLTAGE_BLOCK_LIMIT);
   wire logic wr_clr = (awaddr_q == ADDR_IRQ_CLR);
   wire logic wr_en = (awaddr_q == ADDR_IRQ_EN);
   wire logic wr_grp = ({awaddr_q[7:4], 4'h0} == ADDR_GROUP_BASE) && (awaddr_q[1:0] == 2'b00);
   wire logic wr_ro = (awaddr_q == ADDR_STATUS) || (awaddr_q == ADDR_IRQ_STAT);
   wire logic wr_hit = wr_ctrl || wr_low_voltage_block_limit || wr_clr || wr_en || wr_grp || wr_ro;
   wire logic [1:0] wr_idx = awaddr_q[3:2];
   wire logic [31:0] ctrl_new = ({29'h0, ctrl_q} & ~wmask) | wmasked;
   wire logic [31:0] low_voltage_block_limit_new = ({25'h0, low_voltage_block_limit_q} & ~wmask) | wmasked;
   wire logic [31:0] en_new = ({29'h0, irq_en_q} & ~wmask) | wmasked;
   wire logic [31:0] grp_new = ({5'h0, grp_q[wr_idx]} & ~wmask) | wmasked;
   wire fss_events_t irq_clr = (do_write && wr_clr) ? fss_events_t'(wmasked[2:0]) : '0;

   // active group with settings held inside their ranges
   wire fss_group_t grp_sel = grp_q[ctrl_q[CTRL_GRP_LSB +: 2]];
   wire logic [6:0] sset = (grp_sel.slope < SLOPE_MIN) ? SLOPE_MIN :
                           (grp_sel.slope > SLOPE_MAX) ? SLOPE_MAX : grp_sel.slope;
   wire logic [9:0] top_c = (grp_sel.t_op < DELAY_MIN) ? DELAY_MIN :
                            (grp_sel.t_op > DELAY_MAX) ? DELAY_MAX : grp_sel.t_op;
   wire logic [9:0] minimum_trip_delay_r = (grp_sel.t_min < DELAY_MIN) ? DELAY_MIN :
                             (grp_sel.t_min > DELAY_MAX) ? DELAY_MAX : grp_sel.t_min;
   // minimum above operate delay falls back to definite time
   wire logic [9:0] minimum_trip_delay_c = (minimum_trip_delay_r > top_c) ? top_c : minimum_trip_delay_r;
   wire logic [11:0] top_ticks = 12'(32'(top_c) * STEP_TICKS);
   wire logic [11:0] minimum_trip_delay_ticks = 12'(32'(minimum_trip_delay_c) * STEP_TICKS);
   wire logic [11:0] low_bound = (sset < LOW_SLOPE_SET) ?
      12'(LOW_BASE_TICKS + 32'(LOW_SLOPE_SET - sset) * LOW_STEP_TICKS) : 12'h000;
   wire logic [11:0] win_lo = (low_bound > minimum_trip_delay_ticks) ? low_bound : minimum_trip_delay_ticks;
   wire logic [11:0] win_hi = (win_lo > top_ticks) ? win_lo : top_ticks;
   wire logic [10:0] sset10 = 11'(32'(sset) * SLOPE_INPUT_RATIO);

   // low-voltage block against the shared limit
   wire fss_volt_t vmax_ab = (volt_ab > volt_bc) ? volt_ab : volt_bc;
   wire fss_volt_t vmax = (vmax_ab > volt_ca) ? vmax_ab : volt_ca;
   wire fss_volt_t lv_limit = 11'(32'(low_voltage_block_limit_q) * LV_SCALE);
   wire logic blocked_now = (vmax < lv_limit);
   wire logic hold_idle = blocked_now || !ctrl_q[CTRL_EN_BIT];

   // per-tick measurement and decision terms
   wire logic [15:0] mag = freq_slope[15] ? 16'(-freq_slope) : 16'(freq_slope);
   wire logic excess = (mag > 16'(sset10));
   wire logic [31:0] sum_n = sum_q + 32'(mag);
   wire logic [11:0] n_n = (n_q == 12'hFFF) ? n_q : n_q + 12'h001;
   wire logic [7:0] stab_n = excess ? 8'h00 : ((stab_q == 8'hFF) ? stab_q : stab_q + 8'h01);
   wire logic [7:0] ph_n = ph_q + 8'h01;
   wire logic [31:0] avg_ref = 32'(sset10) * 32'(n_n);
   wire logic [31:0] prod_ref = 32'(sset10) * 32'(top_ticks);
   wire logic avg_above = (sum_n > avg_ref);
   // sum over n ticks equals elapsed time times average slope
   wire logic prod_ok = (sum_n >= prod_ref);
   wire logic in_window = (n_n >= win_lo) && (n_n <= win_hi);
   wire logic trip_cond = in_window && avg_above && (prod_ok || (n_n >= top_ticks));
   wire logic rel_cond = (n_q > win_hi) && (stab_n >= STABLE_TICKS);

   // read path decode
   wire fss_addr_t ra = s_axi_araddr;
   wire logic rd_grp = ({ra[7:4], 4'h0} == ADDR_GROUP_BASE) && (ra[1:0] == 2'b00);
   wire logic rd_hit = rd_grp || (ra == ADDR_CTRL) || (ra == ADDR_LOW_VOLTAGE_BLOCK_LIMIT) || (ra == ADDR_STATUS) ||
                       (ra == ADDR_IRQ_STAT) || (ra == ADDR_IRQ_CLR) || (ra == ADDR_IRQ_EN);
   wire logic [31:0] status_word = {26'h0, state_q, blocked_q, trip_out, start_out};
   wire logic [31:0] rd_data = rd_grp ? {5'h0, grp_q[ra[3:2]]} :
                               (ra == ADDR_CTRL) ? {29'h0, ctrl_q} :
                               (ra == ADDR_LOW_VOLTAGE_BLOCK_LIMIT) ? {25'h0, low_voltage_block_limit_q} :
                               (ra == ADDR_STATUS) ? status_word :
                               (ra == ADDR_IRQ_STAT) ? {29'h0, irq_stat_q} :
                               (ra == ADDR_IRQ_EN) ? {29'h0, irq_en_q} : 32'h0;

   // interrupt events, set wins over clear
   wire fss_events_t ev = '{blocked: blocked_now && !blocked_q,
                            trip: trip_out && !trip_dly_q,
                            start: start_out && !start_dly_q};
   wire fss_events_t irq_stat_d = (irq_stat_q & ~irq_clr) | ev;

   // axi write channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // axi read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_data;
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // software registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= CTRL_RESET;
         low_voltage_block_limit_q <= LOW_VOLTAGE_BLOCK_LIMIT_RESET;
         irq_en_q <= IRQ_EN_RESET;
         for (int i = 0; i < GROUPS; i++) begin
            grp_q[i] <= GROUP_RESET;
         end
      end else if (do_write) begin
         if (wr_ctrl) ctrl_q <= ctrl_new[2:0];
         if (wr_low_voltage_block_limit) low_voltage_block_limit_q <= low_voltage_block_limit_new[6:0];
         if (wr_en) irq_en_q <= en_new[2:0];
         if (wr_grp) grp_q[wr_idx] <= fss_group_t'(grp_new[26:0]);
      end
   end

   // interrupt status and output
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat_q <= '0;
         irq <= 1'b0;
         blocked_q <= 1'b0;
         start_dly_q <= 1'b0;
         trip_dly_q <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         irq <= |(irq_stat_d & irq_en_q);
         blocked_q <= blocked_now;
         start_dly_q <= start_out;
         trip_dly_q <= trip_out;
      end
   end

   // stage sequencer, stepping once per task tick
   always_ff @(posedge aclk) begin
      if (!aresetn || hold_idle) begin
         state_q <= ST_IDLE;
         ph_q <= '0;
         stab_q <= '0;
         n_q <= '0;
         sum_q <= '0;
         start_out <= 1'b0;
         trip_out <= 1'b0;
      end else if (tick) begin
         case (state_q)
            ST_IDLE: begin
               if (excess) begin
                  state_q <= ST_QUAL;
                  ph_q <= 8'h01;
               end
            end
            ST_QUAL: begin
               if (!excess) begin
                  state_q <= ST_IDLE;
                  ph_q <= '0;
               end else if (ph_n >= QUAL_TICKS) begin
                  state_q <= ST_DELAY;
                  ph_q <= '0;
                  sum_q <= '0;
                  n_q <= '0;
                  stab_q <= '0;
               end else begin
                  ph_q <= ph_n;
               end
            end
            ST_DELAY: begin
               sum_q <= sum_n;
               n_q <= n_n;
               stab_q <= stab_n;
               if (ph_n >= START_TICKS) begin
                  state_q <= ST_RUN;
                  start_out <= 1'b1;
               end else begin
                  ph_q <= ph_n;
               end
            end
            ST_RUN: begin
               sum_q <= sum_n;
               n_q <= n_n;
               stab_q <= stab_n;
               if (trip_cond) begin
                  state_q <= ST_TRIP;
                  trip_out <= 1'b1;
               end else if (rel_cond) begin
                  state_q <= ST_IDLE;
                  start_out <= 1'b0;
                  ph_q <= '0;
                  stab_q <= '0;
                  n_q <= '0;
                  sum_q <= '0;
               end
            end
            ST_TRIP: begin
               stab_q <= stab_n;
               if (stab_n >= STABLE_TICKS) begin
                  state_q <= ST_IDLE;
                  start_out <= 1'b0;
                  trip_out <= 1'b0;
                  ph_q <= '0;
                  stab_q <= '0;
                  n_q <= '0;
                  sum_q <= '0;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule // fss_freq_slope_stage
`default_nettype wire

// file: core/fss_pkg.sv
`default_nettype none
package fss_pkg;
   // clock and task tick
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned TICK_MS = 10;
   localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;

   // stage timing in milliseconds and derived tick counts (least times round up)
   localparam int unsigned QUAL_MS = 80;
   localparam int unsigned START_DELAY_MS = 60;
   localparam int unsigned STABLE_MS = 80;
   localparam int unsigned SETTING_STEP_MS = 20;
   localparam logic [7:0] QUAL_TICKS = 8'((QUAL_MS + TICK_MS - 1) / TICK_MS);
   localparam logic [7:0] START_TICKS = 8'((START_DELAY_MS + TICK_MS - 1) / TICK_MS);
   localparam logic [7:0] STABLE_TICKS = 8'((STABLE_MS + TICK_MS - 1) / TICK_MS);
   localparam int unsigned STEP_TICKS = (SETTING_STEP_MS + TICK_MS - 1) / TICK_MS;

   // settings: slope in 0.1 Hz/s, delays in 0.02 s, input slope in 0.01 Hz/s
   localparam logic [6:0] SLOPE_MIN = 7'h02;
   localparam logic [6:0] SLOPE_MAX = 7'h64;
   localparam logic [6:0] LOW_SLOPE_SET = 7'h07;
   localparam int unsigned SLOPE_INPUT_RATIO = 10;
   localparam logic [9:0] DELAY_MIN = 10'h007;
   localparam logic [9:0] DELAY_MAX = 10'h1F4;
   localparam int unsigned LOW_BASE_TICKS_DEF = 20;
   localparam int unsigned LOW_STEP_TICKS_DEF = 6;
   localparam int unsigned GROUPS = 4;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_LOW_VOLTAGE_BLOCK_LIMIT = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h14;
   localparam logic [7:0] ADDR_GROUP_BASE = 8'h20;

   // field positions and reset values
   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned CTRL_GRP_LSB = 1;
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [6:0] LOW_VOLTAGE_BLOCK_LIMIT_RESET = 7'h0A;
   localparam int unsigned LV_SCALE = 10;
   localparam logic [2:0] IRQ_EN_RESET = 3'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef logic [7:0] fss_addr_t;
   typedef logic signed [15:0] fss_slope_t;
   typedef logic [10:0] fss_volt_t;

   typedef struct packed {
      logic [9:0] t_min;
      logic [9:0] t_op;
      logic [6:0] slope;
   } fss_group_t;

   localparam fss_group_t GROUP_RESET = '{t_min: 10'h01E, t_op: 10'h01E, slope: 7'h05};

   typedef struct packed {
      logic blocked;
      logic trip;
      logic start;
   } fss_events_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_QUAL = 3'b001,
      ST_DELAY = 3'b010,
      ST_RUN = 3'b011,
      ST_TRIP = 3'b100
   } fss_state_t;
endpackage
`default_nettype wire

// file: core/fss_tick_divider.sv
`timescale 1ns/10ps
`default_nettype none
module fss_tick_divider #(
   parameter int unsigned DIV = 400000
) (
   input wire logic aclk,
   input wire logic aresetn,
   output logic tick
);
   localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   generate
      if (DIV < 2) begin : g_bad_div
         $error("tick divider needs DIV of at least 2");
      end
   endgenerate

   logic [CW-1:0] cnt_q;
   wire logic wrap = (cnt_q == LAST);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= '0;
         tick <= 1'b0;
      end else begin
         cnt_q <= wrap ? '0 : cnt_q + 1'b1;
         tick <= wrap;
      end
   end
endmodule // fss_tick_divider
`default_nettype wire
